/* inc/mpf_pkg.sv */
package mpf_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_INS_COUNT = 16'h8400;
    localparam logic [15:0] IDX_NV_SAVE = 16'hA004;
    localparam logic [15:0] IDX_CTRL3_SEL = 16'hA005;
    localparam logic [15:0] IDX_CTRL2_SEL = 16'hA006;
    localparam logic [15:0] IDX_CTRL1_SEL = 16'hA007;
    localparam logic [15:0] IDX_ALRM3_SEL = 16'hA008;
    localparam logic [15:0] IDX_ALRM2_SEL = 16'hA009;
    localparam logic [15:0] IDX_ALRM1_SEL = 16'hA00A;
    localparam logic [15:0] IDX_DIR_MODE = 16'hA00B;
    localparam logic [15:0] IDX_GEN_CTRL = 16'hA010;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    // reset values of the select registers
    localparam logic [7:0] RST_CTRL1_SEL = 8'h01;
    localparam logic [7:0] RST_CTRL2_SEL = 8'h00;
    localparam logic [7:0] RST_CTRL3_SEL = 8'h00;
    localparam logic [7:0] RST_ALRM1_SEL = 8'h01;
    localparam logic [7:0] RST_ALRM2_SEL = 8'h02;
    localparam logic [7:0] RST_ALRM3_SEL = 8'h03;
    localparam logic [2:0] RST_DIR_MODE = 3'h0;
    // control pin function codes
    localparam logic [7:0] FN_NONE = 8'h00;
    localparam logic [7:0] FN_TRX_RESET = 8'h01;
    // alarm source codes
    localparam logic [7:0] SRC_OFF = 8'h00;
    localparam logic [7:0] SRC_HIPWR = 8'h01;
    localparam logic [7:0] SRC_READY = 8'h02;
    localparam logic [7:0] SRC_FAULT = 8'h03;
    localparam logic [7:0] SRC_RX_ALARM = 8'h04;
    localparam logic [7:0] SRC_TX_ALARM = 8'h05;
    localparam logic [7:0] SRC_RX_UNLOCK = 8'h06;
    localparam logic [7:0] SRC_TRANSMIT_FUNCTIONALITY_LOSS = 8'h07;
    localparam logic [7:0] SRC_HOST_UNLOCK = 8'h08;
    localparam logic [7:0] SRC_SKEW = 8'h09;
    // general control field positions
    localparam int GC_MOD_RESET = 15;
    localparam int GC_LOW_POWER = 14;
    localparam int GC_TX_DISABLE = 13;
    localparam int GC_CTRL3 = 12;
    localparam int GC_CTRL2 = 11;
    localparam int GC_CTRL1 = 10;
    localparam int GC_ALARM_TEST = 9;
    localparam int GC_TXDIS_PIN = 5;
    localparam int GC_LOPWR_PIN = 4;
    localparam int GC_CTRL3_PIN = 3;
    localparam int GC_CTRL2_PIN = 2;
    localparam int GC_CTRL1_PIN = 1;
    localparam logic [15:0] NV_SAVE_CMD = 16'h0020;
    // long operations, about two seconds each
    localparam longint CLK_PERIOD_NS = 20;
    localparam longint OP_TIME_MS = 2000;
    localparam longint OP_CYCLES = OP_TIME_MS * 64'd1000000 / CLK_PERIOD_NS;

    // alarm indicators, all active high
    typedef struct packed {
        logic high_power_up_done;
        logic mod_ready;
        logic mod_fault;
        logic receive_signal_loss;
        logic network_receive_unlock;
        logic transmit_functionality_loss;
        logic host_transmit_unlock;
        logic transmit_clock_unit_unlock;
        logic host_skew_misaligned;
    } mpf_alarm_src_t;
endpackage

/* rtl/mpf_alarm_mux.sv */
module mpf_alarm_mux
    import mpf_pkg::*;
#(
    parameter bit SKEW_SUPPORTED = 1'b0
) (
    // selection
    input wire logic [7:0] sel,
    input wire mpf_alarm_src_t src,
    // result
    output logic alarm
);
    logic receive_path_alarm;
    logic transmit_path_alarm;

    // grouped path alarms
    assign receive_path_alarm = src.receive_signal_loss |
        src.network_receive_unlock;
    assign transmit_path_alarm = src.transmit_functionality_loss |
        src.host_transmit_unlock | src.transmit_clock_unit_unlock;

    // source decode; reserved codes keep the pin deasserted
    always_comb begin
        case (sel)
            SRC_HIPWR: alarm = src.high_power_up_done;
            SRC_READY: alarm = src.mod_ready;
            SRC_FAULT: alarm = src.mod_fault;
            SRC_RX_ALARM: alarm = receive_path_alarm;
            SRC_TX_ALARM: alarm = transmit_path_alarm;
            SRC_RX_UNLOCK: alarm = src.network_receive_unlock;
            SRC_TRANSMIT_FUNCTIONALITY_LOSS: alarm = src.transmit_functionality_loss;
            SRC_HOST_UNLOCK: alarm = src.host_transmit_unlock;
            SRC_SKEW: alarm = SKEW_SUPPORTED & src.host_skew_misaligned;
            default: alarm = 1'b0;
        endcase
    end
endmodule // mpf_alarm_mux

/* rtl/mpf_regs.sv */
module mpf_regs
    import mpf_pkg::*;
#(
    parameter longint OP_CYCLES_P = OP_CYCLES,
    parameter bit SKEW_SUPPORTED = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // module pins from the host
    input wire logic [2:0] prog_control_pin,
    input wire logic module_reset_pin_n,
    input wire logic low_power_pin,
    input wire logic transmit_disable_pin,
    // device state
    input wire logic init_state,
    input wire logic module_inserted,
    input wire logic global_alarm_in,
    input wire mpf_alarm_src_t alarm_src,
    // device outputs
    output logic [2:0] prog_alarm_pin,
    output logic transceiver_ic_reset_n,
    output logic hw_interlock_high_bit,
    output logic hw_interlock_low_bit,
    output logic module_reset,
    output logic low_power,
    output logic transmit_disable,
    output logic global_alarm_output,
    output logic [2:0] direction_mode,
    output logic nv_save_active,
    output logic count_clear_active
);
    logic [7:0] ctrl_sel_r [3];
    logic [7:0] alarm_sel_r [3];
    logic [2:0] dir_mode_r;
    logic [15:0] ins_count_r;
    logic soft_reset_r;
    logic soft_lopwr_r;
    logic soft_txdis_r;
    logic [2:0] soft_ctrl_r;
    logic soft_alarm_test_r;
    logic [31:0] save_cnt_r;
    logic [31:0] clear_cnt_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic hit;
    logic setup;
    logic wr_go;
    logic [15:0] idx;
    logic [15:0] wd;
    logic [2:0] pin_asserted;
    logic [2:0] ctrl_combined;
    logic [2:0] alarm_nxt;
    logic [15:0] gc_read;
    logic trx_reset_nxt;

    assign idx = paddr[17:2];
    assign wd = pwdata[15:0];
    assign setup = psel & penable & ~pready;
    assign wr_go = psel & penable & pready & pwrite & ~pslverr;
    // programmable pins are low-true when carrying the reset function
    assign pin_asserted = ~prog_control_pin;
    assign ctrl_combined = pin_asserted | soft_ctrl_r;

    // address decode: mapped registers only, aligned words
    always_comb begin
        hit = 1'b1;
        if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:18] != '0) begin
            hit = 1'b0;
        end else if (idx == IDX_INS_COUNT) begin
            hit = 1'b1;
        end else if (idx >= IDX_NV_SAVE && idx <= IDX_DIR_MODE) begin
            hit = 1'b1;
        end else if (idx == IDX_GEN_CTRL) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // general control readback with live pin states
    always_comb begin
        gc_read = 16'h0000;
        gc_read[GC_LOW_POWER] = soft_lopwr_r;
        gc_read[GC_TX_DISABLE] = soft_txdis_r;
        gc_read[GC_CTRL3] = soft_ctrl_r[2];
        gc_read[GC_CTRL2] = soft_ctrl_r[1];
        gc_read[GC_CTRL1] = soft_ctrl_r[0];
        gc_read[GC_ALARM_TEST] = soft_alarm_test_r;
        gc_read[GC_TXDIS_PIN] = transmit_disable_pin;
        gc_read[GC_LOPWR_PIN] = low_power_pin;
        gc_read[GC_CTRL3_PIN] = pin_asserted[2];
        gc_read[GC_CTRL2_PIN] = pin_asserted[1];
        gc_read[GC_CTRL1_PIN] = pin_asserted[0];
    end

    // read mux; upper bits of every word read zero
    always_comb begin
        rdata_nxt = '0;
        if (idx == IDX_INS_COUNT) begin
            rdata_nxt[15:0] = ins_count_r;
        end else if (idx == IDX_NV_SAVE) begin
            rdata_nxt[15:0] = nv_save_active ? NV_SAVE_CMD : 16'h0000;
        end else if (idx == IDX_CTRL3_SEL) begin
            rdata_nxt[7:0] = ctrl_sel_r[2];
        end else if (idx == IDX_CTRL2_SEL) begin
            rdata_nxt[7:0] = ctrl_sel_r[1];
        end else if (idx == IDX_CTRL1_SEL) begin
            rdata_nxt[7:0] = ctrl_sel_r[0];
        end else if (idx == IDX_ALRM3_SEL) begin
            rdata_nxt[7:0] = alarm_sel_r[2];
        end else if (idx == IDX_ALRM2_SEL) begin
            rdata_nxt[7:0] = alarm_sel_r[1];
        end else if (idx == IDX_ALRM1_SEL) begin
            rdata_nxt[7:0] = alarm_sel_r[0];
        end else if (idx == IDX_DIR_MODE) begin
            rdata_nxt[2:0] = dir_mode_r;
        end else if (idx == IDX_GEN_CTRL) begin
            rdata_nxt[15:0] = gc_read;
        end
    end

    // one wait state: answer registered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= ~hit;
            prdata <= (hit && !pwrite) ? rdata_nxt : '0;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // control pin function selects, low byte only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_sel_r[0] <= RST_CTRL1_SEL;
            ctrl_sel_r[1] <= RST_CTRL2_SEL;
            ctrl_sel_r[2] <= RST_CTRL3_SEL;
        end else if (wr_go) begin
            if (idx == IDX_CTRL1_SEL) begin
                ctrl_sel_r[0] <= wd[7:0];
            end else if (idx == IDX_CTRL2_SEL) begin
                ctrl_sel_r[1] <= wd[7:0];
            end else if (idx == IDX_CTRL3_SEL) begin
                ctrl_sel_r[2] <= wd[7:0];
            end
        end
    end

    // alarm source selects; unsupported skew code is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_sel_r[0] <= RST_ALRM1_SEL;
            alarm_sel_r[1] <= RST_ALRM2_SEL;
            alarm_sel_r[2] <= RST_ALRM3_SEL;
        end else if (wr_go && !(wd[7:0] == SRC_SKEW && !SKEW_SUPPORTED)) begin
            if (idx == IDX_ALRM1_SEL) begin
                alarm_sel_r[0] <= wd[7:0];
            end else if (idx == IDX_ALRM2_SEL) begin
                alarm_sel_r[1] <= wd[7:0];
            end else if (idx == IDX_ALRM3_SEL) begin
                alarm_sel_r[2] <= wd[7:0];
            end
        end
    end

    // direction mode select; stored as written, reserved codes too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_mode_r <= RST_DIR_MODE;
        end else if (wr_go && idx == IDX_DIR_MODE) begin
            dir_mode_r <= wd[2:0];
        end
    end

    // soft general control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_lopwr_r <= 1'b0;
            soft_txdis_r <= 1'b0;
            soft_ctrl_r <= 3'h0;
            soft_alarm_test_r <= 1'b0;
        end else if (wr_go && idx == IDX_GEN_CTRL) begin
            soft_lopwr_r <= wd[GC_LOW_POWER];
            soft_txdis_r <= wd[GC_TX_DISABLE];
            soft_ctrl_r <= wd[GC_CTRL3:GC_CTRL1];
            soft_alarm_test_r <= wd[GC_ALARM_TEST];
        end
    end

    // soft module reset lasts one cycle; writing 0 does nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_r <= 1'b0;
        end else begin
            soft_reset_r <= wr_go && idx == IDX_GEN_CTRL &&
                wd[GC_MOD_RESET];
        end
    end

    // insertion counter; a write starts the slow user reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ins_count_r <= 16'h0000;
            clear_cnt_r <= 32'h0000_0000;
        end else if (clear_cnt_r != 32'h0000_0000) begin
            clear_cnt_r <= clear_cnt_r - 32'h0000_0001;
            if (clear_cnt_r == 32'h0000_0001) begin
                ins_count_r <= 16'h0000;
            end
        end else if (wr_go && idx == IDX_INS_COUNT) begin
            clear_cnt_r <= OP_CYCLES_P[31:0];
        end else if (module_inserted && ins_count_r != 16'hFFFF) begin
            ins_count_r <= ins_count_r + 16'h0001;
        end
    end

    // non-volatile save: busy for the commit time after the command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            save_cnt_r <= 32'h0000_0000;
        end else if (save_cnt_r != 32'h0000_0000) begin
            save_cnt_r <= save_cnt_r - 32'h0000_0001;
        end else if (wr_go && idx == IDX_NV_SAVE && wd == NV_SAVE_CMD) begin
            save_cnt_r <= OP_CYCLES_P[31:0];
        end
    end

    // alarm pin source multiplexers
    for (genvar i = 0; i < 3; i++) begin : g_alarm
        mpf_alarm_mux #(
            .SKEW_SUPPORTED(SKEW_SUPPORTED)
        ) u_mux (
            .sel(alarm_sel_r[i]),
            .src(alarm_src),
            .alarm(alarm_nxt[i])
        );
    end

    // transceiver reset: only pins assigned that function, and not in init
    always_comb begin
        trx_reset_nxt = 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (ctrl_sel_r[k] == FN_TRX_RESET && ctrl_combined[k]) begin
                trx_reset_nxt = 1'b1;
            end
        end
        if (init_state) begin
            trx_reset_nxt = 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_alarm_pin <= 3'h0;
            transceiver_ic_reset_n <= 1'b1;
            hw_interlock_high_bit <= 1'b0;
            hw_interlock_low_bit <= 1'b0;
            module_reset <= 1'b0;
            low_power <= 1'b0;
            transmit_disable <= 1'b0;
            global_alarm_output <= 1'b0;
            direction_mode <= RST_DIR_MODE;
            nv_save_active <= 1'b0;
            count_clear_active <= 1'b0;
        end else begin
            prog_alarm_pin <= alarm_nxt;
            transceiver_ic_reset_n <= ~trx_reset_nxt;
            hw_interlock_high_bit <= init_state & pin_asserted[2];
            hw_interlock_low_bit <= init_state & pin_asserted[1];
            module_reset <= soft_reset_r | ~module_reset_pin_n;
            low_power <= soft_lopwr_r | low_power_pin;
            transmit_disable <= soft_txdis_r | transmit_disable_pin;
            global_alarm_output <= soft_alarm_test_r | global_alarm_in;
            direction_mode <= dir_mode_r;
            nv_save_active <= (save_cnt_r != 32'h0000_0000);
            count_clear_active <= (clear_cnt_r != 32'h0000_0000);
        end
    end

    // checks
    sequence s_apb_setup;
        psel && penable && !pready;
    endsequence
    sequence s_apb_answer;
        pready ##1 !pready;
    endsequence

    property p_apb_one_wait;
        @(posedge pclk) disable iff (!presetn)
        s_apb_setup |=> s_apb_answer;
    endproperty
    a_apb_one_wait: assert property (p_apb_one_wait)
        else $error("apb answer not one cycle after access");

    property p_soft_reset_pulse;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && idx == IDX_GEN_CTRL && wd[GC_MOD_RESET]) |=>
            soft_reset_r ##1 (!soft_reset_r && module_reset);
    endproperty
    a_soft_reset_pulse: assert property (p_soft_reset_pulse)
        else $error("soft module reset not a one cycle pulse");

    property p_alarm_test;
        @(posedge pclk) disable iff (!presetn)
        soft_alarm_test_r |=> global_alarm_output;
    endproperty
    a_alarm_test: assert property (p_alarm_test)
        else $error("forced global alarm missing");

    property p_skew_ignored;
        @(posedge pclk) disable iff (!presetn)
        (!SKEW_SUPPORTED && wr_go && wd[7:0] == SRC_SKEW &&
            idx == IDX_ALRM1_SEL) |=> $stable(alarm_sel_r[0]);
    endproperty
    a_skew_ignored: assert property (p_skew_ignored)
        else $error("unsupported skew code was stored");

    property p_trx_reset;
        @(posedge pclk) disable iff (!presetn)
        (!init_state && ctrl_sel_r[0] == FN_TRX_RESET &&
            !prog_control_pin[0]) |=> !transceiver_ic_reset_n;
    endproperty
    a_trx_reset: assert property (p_trx_reset)
        else $error("low control pin did not reset transceiver");

    property p_init_no_reset;
        @(posedge pclk) disable iff (!presetn)
        init_state |=> transceiver_ic_reset_n;
    endproperty
    a_init_no_reset: assert property (p_init_no_reset)
        else $error("transceiver reset during initialize state");

    property p_alarm_off;
        @(posedge pclk) disable iff (!presetn)
        (alarm_sel_r[2] == SRC_OFF) |=> !prog_alarm_pin[2];
    endproperty
    a_alarm_off: assert property (p_alarm_off)
        else $error("alarm pin asserted with source off");

    property p_fault_route;
        @(posedge pclk) disable iff (!presetn)
        (alarm_sel_r[2] == SRC_FAULT) |=>
            (prog_alarm_pin[2] == $past(alarm_src.mod_fault));
    endproperty
    a_fault_route: assert property (p_fault_route)
        else $error("fault source not routed");

    property p_save_busy;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && idx == IDX_NV_SAVE && wd == NV_SAVE_CMD &&
            save_cnt_r == 32'h0000_0000) |=> ##1 nv_save_active;
    endproperty
    a_save_busy: assert property (p_save_busy)
        else $error("save command did not start commit");
endmodule // mpf_regs

/* test/mpf_host_model.sv */
module mpf_host_model
    import mpf_pkg::*;
(
    // clock and answer
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [DATA_W-1:0] prdata,
    // apb request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [DATA_W-1:0] pwdata,
    // module pins
    output logic [2:0] prog_control_pin,
    output logic module_reset_pin_n,
    output logic low_power_pin,
    output logic transmit_disable_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus; pins deasserted, control pins idle high
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        prog_control_pin = 3'h7;
        module_reset_pin_n = 1'b1;
        low_power_pin = 1'b0;
        transmit_disable_pin = 1'b0;
    end
    // pin levels change just after an edge; a low control pin asserts
    task automatic pins(input logic [2:0] cn, input logic rn,
        input logic lp, input logic td);
        @(posedge pclk);
        prog_control_pin <= cn;
        module_reset_pin_n <= rn;
        low_power_pin <= lp;
        transmit_disable_pin <= td;
    endtask
    // request held until pready is seen high; bound guards a dead slave
    task automatic xfer(input logic w, input logic [15:0] idx,
        input logic [15:0] d, output logic [31:0] q, output logic er,
        output logic to);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {14'h0, idx, 2'h0};
        pwdata <= {16'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        er = pslverr;
        to = (n >= 16);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // mpf_host_model

/* test/module_pin_function_control_tb.sv */
module module_pin_function_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mpf_pkg::*;
    localparam longint OP = 20;
    // bus, pins and device state
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [2:0] prog_control_pin, prog_alarm_pin, direction_mode;
    logic module_reset_pin_n, low_power_pin, transmit_disable_pin;
    logic init_state, module_inserted, global_alarm_in;
    mpf_alarm_src_t alarm_src;
    logic transceiver_ic_reset_n, hw_interlock_high_bit;
    logic hw_interlock_low_bit, module_reset, low_power;
    logic transmit_disable, global_alarm_output, nv_save_active;
    logic count_clear_active;
    logic [1:0] il;
    logic [3:0] outs;
    int fails, compares;
    // grouped views for compact compares
    assign il = {hw_interlock_high_bit, hw_interlock_low_bit};
    assign outs = {module_reset, low_power, transmit_disable,
        global_alarm_output};
    mpf_regs #(.OP_CYCLES_P(OP)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .prog_control_pin,
        .module_reset_pin_n, .low_power_pin, .transmit_disable_pin,
        .init_state, .module_inserted, .global_alarm_in, .alarm_src,
        .prog_alarm_pin, .transceiver_ic_reset_n, .hw_interlock_high_bit,
        .hw_interlock_low_bit, .module_reset, .low_power,
        .transmit_disable, .global_alarm_output, .direction_mode,
        .nv_save_active, .count_clear_active
    );
    mpf_host_model host (
        .pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prog_control_pin, .module_reset_pin_n,
        .low_power_pin, .transmit_disable_pin
    );
    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // verdict and end of run
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // a hung transfer ends the run
    task automatic acc(input logic w, input logic [15:0] idx,
        input logic [15:0] d, output logic [31:0] q, output logic er);
        logic to;
        host.xfer(w, idx, d, q, er, to);
        if (to) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic [31:0] q;
        logic er;
        acc(1'b1, idx, d, q, er);
    endtask
    task automatic rd(input string nm, input logic [15:0] idx,
        input logic [31:0] e);
        logic [31:0] q;
        logic er;
        acc(1'b0, idx, 16'h0, q, er);
        chk(nm, e, q);
    endtask
    // outputs are registered; give them time to land
    task automatic settle();
        repeat (3) @(posedge pclk);
    endtask
    function automatic logic ex(input logic [7:0] c,
        input mpf_alarm_src_t s);
        case (c)
            8'h01: return s.high_power_up_done;
            8'h02: return s.mod_ready;
            8'h03: return s.mod_fault;
            8'h04: return s.receive_signal_loss | s.network_receive_unlock;
            8'h05: return s.transmit_functionality_loss |
                s.host_transmit_unlock | s.transmit_clock_unit_unlock;
            8'h06: return s.network_receive_unlock;
            8'h07: return s.transmit_functionality_loss;
            8'h08: return s.host_transmit_unlock;
            default: return 1'b0;
        endcase
    endfunction
    task automatic t_reset();
        rd("ctrl1 sel", IDX_CTRL1_SEL, 32'h1);
        rd("ctrl2 sel", IDX_CTRL2_SEL, 32'h0);
        rd("ctrl3 sel", IDX_CTRL3_SEL, 32'h0);
        rd("alarm1 sel", IDX_ALRM1_SEL, 32'h1);
        rd("alarm2 sel", IDX_ALRM2_SEL, 32'h2);
        rd("alarm3 sel", IDX_ALRM3_SEL, 32'h3);
        rd("mode", IDX_DIR_MODE, 32'h0);
        rd("gen ctrl", IDX_GEN_CTRL, 32'h0);
    endtask
    task automatic t_ctrl();
        host.pins(3'h6, 1'b1, 1'b0, 1'b0);
        settle();
        chk("trx pin1", 32'h0, 32'(transceiver_ic_reset_n));
        rd("pin1 state", IDX_GEN_CTRL, 32'h2);
        host.pins(3'h7, 1'b1, 1'b0, 1'b0);
        wr(IDX_GEN_CTRL, 16'h0400);
        settle();
        chk("trx soft1", 32'h0, 32'(transceiver_ic_reset_n));
        wr(IDX_CTRL1_SEL, 16'h0000);
        settle();
        chk("trx none", 32'h1, 32'(transceiver_ic_reset_n));
        wr(IDX_CTRL3_SEL, 16'hFFFF);
        rd("ctrl3 rsvd", IDX_CTRL3_SEL, 32'hFF);
        wr(IDX_CTRL3_SEL, 16'h0001);
        wr(IDX_GEN_CTRL, 16'h1000);
        settle();
        chk("trx soft3", 32'h0, 32'(transceiver_ic_reset_n));
        wr(IDX_GEN_CTRL, 16'h0000);
        init_state <= 1'b1;
        host.pins(3'h3, 1'b1, 1'b0, 1'b0);
        settle();
        chk("interlock", 32'h2, 32'(il));
        chk("trx init", 32'h1, 32'(transceiver_ic_reset_n));
        host.pins(3'h5, 1'b1, 1'b0, 1'b0);
        settle();
        chk("interlock", 32'h1, 32'(il));
        init_state <= 1'b0;
        host.pins(3'h7, 1'b1, 1'b0, 1'b0);
    endtask
    // every source code against each single indicator
    task automatic t_alarm();
        logic [2:0] e;
        for (int c = 0; c <= 10; c++) begin
            if (c == 9) wr(IDX_ALRM1_SEL, 16'h0000);
            wr(IDX_ALRM1_SEL, 16'(c));
            rd("alarm1 sel", IDX_ALRM1_SEL, (c == 9) ? 0 : 32'(c));
            for (int b = 0; b < 9; b++) begin
                alarm_src <= mpf_alarm_src_t'(9'h1 << b);
                settle();
                e = {ex(8'h3, alarm_src), ex(8'h2, alarm_src),
                    ex(8'(c), alarm_src)};
                chk("alarm", 32'(e), 32'(prog_alarm_pin));
            end
        end
        // a pin switched off must stay low with every source raised
        wr(IDX_ALRM3_SEL, 16'h0000);
        alarm_src <= mpf_alarm_src_t'(9'h1FF);
        settle();
        chk("alarm3 off", 32'h0, 32'(prog_alarm_pin[2]));
        alarm_src <= mpf_alarm_src_t'(9'h0);
    endtask
    task automatic t_gen();
        int n;
        n = 0;
        wr(IDX_GEN_CTRL, 16'h8000);
        repeat (6) begin
            @(posedge pclk);
            n += int'(module_reset === 1'b1);
        end
        chk("reset pulse", 32'h1, 32'(n));
        rd("self clear", IDX_GEN_CTRL, 32'h0);
        wr(IDX_GEN_CTRL, 16'h7FFF);
        rd("gen rw", IDX_GEN_CTRL, 32'h7E00);
        chk("soft outs", 32'h7, 32'(outs));
        wr(IDX_GEN_CTRL, 16'h0000);
        host.pins(3'h7, 1'b0, 1'b1, 1'b1);
        global_alarm_in <= 1'b1;
        settle();
        chk("pin outs", 32'hF, 32'(outs));
        rd("pin states", IDX_GEN_CTRL, 32'h30);
        host.pins(3'h7, 1'b1, 1'b0, 1'b0);
        global_alarm_in <= 1'b0;
    endtask
    task automatic t_mode();
        for (int c = 0; c < 8; c++) begin
            wr(IDX_DIR_MODE, 16'hFFF8 | 16'(c));
            settle();
            chk("mode out", 32'(c), 32'(direction_mode));
            rd("mode reg", IDX_DIR_MODE, 32'(c));
        end
    endtask
    // cycles that a busy flag stays high in a fixed window
    task automatic busy(input bit sv, output int n);
        n = 0;
        repeat (60) begin
            @(posedge pclk);
            n += int'((sv ? nv_save_active : count_clear_active) === 1'b1);
        end
    endtask
    task automatic t_long();
        int n;
        logic [31:0] q;
        logic er;
        repeat (3) begin
            @(posedge pclk);
            module_inserted <= 1'b1;
            @(posedge pclk);
            module_inserted <= 1'b0;
        end
        rd("count", IDX_INS_COUNT, 32'h3);
        wr(IDX_INS_COUNT, 16'h1234);
        busy(1'b0, n);
        chk("clear len", 32'(OP), 32'(n));
        rd("count", IDX_INS_COUNT, 32'h0);
        wr(IDX_NV_SAVE, 16'h0021);
        busy(1'b1, n);
        chk("bad save", 32'h0, 32'(n));
        wr(IDX_NV_SAVE, NV_SAVE_CMD);
        busy(1'b1, n);
        chk("save len", 32'(OP), 32'(n));
        wr(IDX_NV_SAVE, NV_SAVE_CMD);
        rd("save busy", IDX_NV_SAVE, 32'h20);
        busy(1'b1, n);
        rd("save idle", IDX_NV_SAVE, 32'h0);
        acc(1'b0, 16'hA00C, 16'h0, q, er);
        chk("unmapped", 32'h1, {q[30:0], er});
    endtask
    initial begin
        presetn = 1'b0;
        init_state = 1'b0;
        module_inserted = 1'b0;
        global_alarm_in = 1'b0;
        alarm_src = mpf_alarm_src_t'(9'h0);
        fails = 0;
        compares = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_ctrl();
        t_alarm();
        t_gen();
        t_mode();
        t_long();
        tally_and_finish();
    end
endmodule // module_pin_function_control_tb
